/* src/translation_memtype_and_invalidation.sv */
// Memory-type resolution and split invalidation checks with Avalon-MM registers
//
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Leaf entry bits 30-29 select keep, non-cacheable main, or strong I/O.
// - Non-leaf entry with nonzero bits 30-29 raises a page fault.
// - Leaf entry holding memory type 3 raises a page fault.
// - A vacant physical attribute stays vacant under any memory type.
// - I/O page mapped non-cacheable: weak ordering, fences see both classes.
// - Main page mapped strong I/O: channel 0 ordering, fences see both.
// - Strong I/O pages may fault misaligned accesses.
// - Guest-physical stage type overrides physical attributes when its mode is nonzero.
// - Guest-virtual stage type overrides intermediate attributes when its mode is nonzero.
// - Supervisor invalidate removes what a full fence with same operands removes.
// - Supervisor invalidate orders only against fences, not loads and stores.
// - Store-to-invalidate fence orders visible stores before later invalidates.
// - Invalidate-to-implicit fence orders invalidates before later table walks.
// - Fence, invalidate, fence in order act as one full fence.
// - Guest invalidates behave alike; guest-physical keyed by machine tag.
// - Any invalidate in user mode is an illegal instruction.
// - Supervisor or guest-physical invalidate in supervisor mode under machine trap bit is illegal.
// - Guest invalidates in virtual modes, supervisor one in virtual user: virtual trap.
// - Guest trap bit makes supervisor invalidate in virtual supervisor a virtual trap.
// - Split fences: illegal in user mode, virtual trap in virtual user.
// - Split fences ignore both trap bits in supervisor modes.
// - Invalidates run as full fences; split fences are no-operations.
module translation_memtype_and_invalidation (
	input  wire logic        core_clk,
	input  wire logic        reset,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic [31:0] srcVaddr,
	input  wire logic [31:0] srcTag,
	output logic             flushValid,
	output logic [1:0]       flushKind,
	output logic [31:0]      flushVaddr,
	output logic [15:0]      flushTag,
	output logic             flushAllAddr,
	output logic             flushAllTag,
	output logic             ioOrdered,
	output logic             fenceBoth
);
	typedef struct packed {
		xlate_pkg::bus_state_t bus;
		logic [31:0] rdata;
		logic [31:0] insn;
		logic [2:0]  mode;
		logic        machineVmTrapBit;
		logic        guestVmTrapBit;
		logic        gpStageOn;
		logic        gvStageOn;
		logic [1:0]  gpType;
		logic        gpLeaf;
		logic [1:0]  gvType;
		logic        gvLeaf;
		logic [1:0]  physAttr;
		logic        misaligned;
		logic [1:0]  finalAttr;
		logic        finalIoOrd;
		logic        finalBoth;
		logic [1:0]  pageExc;
		logic [1:0]  insnExc;
		logic        insnOk;
		logic        fValid;
		logic [1:0]  fKind;
		logic [31:0] fVaddr;
		logic [15:0] fTag;
		logic        fAllAddr;
		logic        fAllTag;
		logic [31:0] invCount;
	} state_t;

	state_t cur;
	state_t next_cur;

	// Apply one stage of memory type over incoming attributes
	function automatic logic [1:0] overlay(input logic [1:0] base, input logic [1:0] pmt);
		logic [1:0] r;
		r = base;
		if (base == xlate_pkg::ATTR_VACANT) begin
			r = xlate_pkg::ATTR_VACANT;
		end else if (pmt == xlate_pkg::PMT_NC) begin
			r = xlate_pkg::ATTR_MAIN;
		end else if (pmt == xlate_pkg::PMT_IO) begin
			r = xlate_pkg::ATTR_IO;
		end
		return r;
	endfunction

	// Entry fault: reserved type in leaf, any nonzero type in non-leaf
	function automatic logic entryFault(input logic leaf, input logic [1:0] pmt);
		logic f;
		f = leaf ? (pmt == xlate_pkg::PMT_RSVD) : (pmt != xlate_pkg::PMT_KEEP);
		return f;
	endfunction

	// Invalidate flavour; guest-physical one is keyed by machine tags
	function automatic logic [1:0] flushKindOf(input logic [6:0] fn);
		logic [1:0] k;
		case (fn)
			xlate_pkg::F7_SUP_INV: begin
				k = xlate_pkg::INV_SUP;
			end
			xlate_pkg::F7_GV_INV: begin
				k = xlate_pkg::INV_GV;
			end
			default: begin
				k = xlate_pkg::INV_GP;
			end
		endcase
		return k;
	endfunction

	logic [6:0] opc;
	logic [6:0] f7;
	logic [4:0] rs2f;
	logic [4:0] rs1f;
	logic [2:0] f3;
	logic [4:0] rdf;
	assign opc = cur.insn[6:0];
	assign rdf = cur.insn[11:7];
	assign f3 = cur.insn[14:12];
	assign rs1f = cur.insn[19:15];
	assign rs2f = cur.insn[24:20];
	assign f7 = cur.insn[31:25];

	always_comb begin
		logic [1:0] mid;
		logic [1:0] fin;
		logic [1:0] pex;
		logic [1:0] iex;
		logic       isInv;
		logic       isFence;
		logic       sys;
		logic       virt;
		next_cur = cur;
		mid = 2'h0;
		fin = 2'h0;
		pex = xlate_pkg::EXC_NONE;
		iex = xlate_pkg::EXC_NONE;
		isInv = 1'b0;
		isFence = 1'b0;
		sys = (opc == xlate_pkg::OPC_SYSTEM) && (f3 == 3'h0) && (rdf == 5'h00);
		virt = cur.mode[2];
		next_cur.fValid = 1'b0;

		// Two-stage memory type composition
		// Stage off: its entry word is ignored, so a stale word cannot fault
		mid = cur.gpStageOn ? overlay(cur.physAttr, cur.gpType) : cur.physAttr;
		fin = cur.gvStageOn ? overlay(mid, cur.gvType) : mid;
		if ((cur.gpStageOn && entryFault(cur.gpLeaf, cur.gpType)) ||
				(cur.gvStageOn && entryFault(cur.gvLeaf, cur.gvType))) begin
			pex = xlate_pkg::EXC_PAGE;
		end else if (fin == xlate_pkg::ATTR_IO && cur.misaligned) begin
			pex = xlate_pkg::EXC_PAGE;
		end
		next_cur.finalAttr = fin;
		// Ordering follows the final class; fences see both if class changed
		next_cur.finalIoOrd = (fin == xlate_pkg::ATTR_IO);
		next_cur.finalBoth = (fin != xlate_pkg::ATTR_VACANT) && (fin != cur.physAttr);
		next_cur.pageExc = pex;

		// Privilege checks of the decoded instruction
		if (sys && (f7 == xlate_pkg::F7_SUP_INV)) begin
			isInv = 1'b1;
			if (cur.mode == xlate_pkg::MODE_U) begin
				iex = xlate_pkg::EXC_ILLEGAL;
			end else if (cur.mode == xlate_pkg::MODE_VU) begin
				iex = xlate_pkg::EXC_VIRTUAL;
			end else if (cur.mode == xlate_pkg::MODE_S && cur.machineVmTrapBit) begin
				iex = xlate_pkg::EXC_ILLEGAL;
			end else if (cur.mode == xlate_pkg::MODE_VS && cur.guestVmTrapBit) begin
				iex = xlate_pkg::EXC_VIRTUAL;
			end
		end else if (sys && (f7 == xlate_pkg::F7_GV_INV || f7 == xlate_pkg::F7_GP_INV)) begin
			isInv = 1'b1;
			if (cur.mode == xlate_pkg::MODE_U) begin
				iex = xlate_pkg::EXC_ILLEGAL;
			end else if (virt) begin
				iex = xlate_pkg::EXC_VIRTUAL;
			end else if (f7 == xlate_pkg::F7_GP_INV && cur.mode == xlate_pkg::MODE_S &&
					cur.machineVmTrapBit) begin
				iex = xlate_pkg::EXC_ILLEGAL;
			end
		end else if (sys && f7 == xlate_pkg::F7_FENCE_GRP && rs1f == 5'h00 &&
				(rs2f == xlate_pkg::RS2_ST_INV || rs2f == xlate_pkg::RS2_INV_IMP)) begin
			isFence = 1'b1;
			// Trap bits deliberately not consulted
			// Only ordering effects, nothing for a trap handler to emulate
			if (cur.mode == xlate_pkg::MODE_U) begin
				iex = xlate_pkg::EXC_ILLEGAL;
			end else if (cur.mode == xlate_pkg::MODE_VU) begin
				iex = xlate_pkg::EXC_VIRTUAL;
			end
		end else begin
			iex = xlate_pkg::EXC_ILLEGAL;
		end

		// Bus slave: two wait cycles (IDLE, WAIT), then answer
		case (cur.bus)
			xlate_pkg::IDLE: begin
				if (read || write) begin
					next_cur.bus = xlate_pkg::WAIT;
				end
			end
			xlate_pkg::WAIT: begin
				next_cur.bus = xlate_pkg::ANSWER;
				// Read data kept across writes; it only changes on a read
				if (write) begin
					case (address)
						xlate_pkg::ADDR_INSN: begin
							next_cur.insn = writedata;
						end
						xlate_pkg::ADDR_PRIV: begin
							next_cur.mode = writedata[2:0];
							next_cur.machineVmTrapBit = writedata[4];
							next_cur.guestVmTrapBit = writedata[5];
							next_cur.gpStageOn = writedata[8];
							next_cur.gvStageOn = writedata[9];
						end
						xlate_pkg::ADDR_PTE_LO: begin
							next_cur.gvType = writedata[xlate_pkg::PMT_HI:xlate_pkg::PMT_LO];
							next_cur.gvLeaf = writedata[0];
						end
						xlate_pkg::ADDR_PTE_HI: begin
							next_cur.gpType = writedata[xlate_pkg::PMT_HI:xlate_pkg::PMT_LO];
							next_cur.gpLeaf = writedata[0];
						end
						xlate_pkg::ADDR_ATTR: begin
							next_cur.physAttr = writedata[1:0];
							next_cur.misaligned = writedata[4];
						end
						xlate_pkg::ADDR_INV: begin
							// Execute: simple form, every invalidate is a full fence
							next_cur.insnExc = iex;
							next_cur.insnOk = (iex == xlate_pkg::EXC_NONE);
							if (iex == xlate_pkg::EXC_NONE && isInv) begin
								next_cur.fValid = 1'b1;
								next_cur.fKind = flushKindOf(f7);
								next_cur.fVaddr = srcVaddr;
								next_cur.fTag = srcTag[15:0];
								next_cur.fAllAddr = (rs1f == 5'h00);
								next_cur.fAllTag = (rs2f == 5'h00);
								next_cur.invCount = cur.invCount + 32'h1;
							end
							// Fences complete as no-operations; the flush is already
							// done in order, so stores and walks need no stall
							if (isFence) begin
								next_cur.fValid = 1'b0;
							end
						end
						default: begin
						end
					endcase
				end else begin
					case (address)
						xlate_pkg::ADDR_INSN: begin
							next_cur.rdata = cur.insn;
						end
						xlate_pkg::ADDR_PRIV: begin
							next_cur.rdata = {
								22'h0,
								cur.gvStageOn,
								cur.gpStageOn,
								2'h0,
								cur.guestVmTrapBit,
								cur.machineVmTrapBit,
								1'b0,
								cur.mode
							};
						end
						xlate_pkg::ADDR_RESULT: begin
							next_cur.rdata = {
								24'h0,
								cur.finalBoth,
								cur.finalIoOrd,
								cur.pageExc,
								2'h0,
								cur.finalAttr
							};
						end
						xlate_pkg::ADDR_INV: begin
							next_cur.rdata = {
								29'h0,
								cur.insnOk,
								cur.insnExc
							};
						end
						xlate_pkg::ADDR_INV_VA: begin
							next_cur.rdata = cur.invCount;
						end
						xlate_pkg::ADDR_INV_TAG: begin
							next_cur.rdata = {16'h0, cur.fTag};
						end
						default: begin
							next_cur.rdata = 32'h0;
						end
					endcase
				end
			end
			xlate_pkg::ANSWER: begin
				next_cur.bus = xlate_pkg::IDLE;
			end
			default: next_cur.bus = xlate_pkg::IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// Released only in the answer cycle; the master holds its request till then
	assign waitrequest = (read || write) && (cur.bus != xlate_pkg::ANSWER);
	assign readdata = cur.rdata;
	assign flushValid = cur.fValid;
	assign flushKind = cur.fKind;
	assign flushVaddr = cur.fVaddr;
	assign flushTag = cur.fTag;
	assign flushAllAddr = cur.fAllAddr;
	assign flushAllTag = cur.fAllTag;
	assign ioOrdered = cur.finalIoOrd;
	assign fenceBoth = cur.finalBoth;
endmodule
`default_nettype wire

/* src/xlate_pkg.sv */
// Constants and types for the memory-type and invalidation block
package xlate_pkg;
	localparam logic [7:0]  ADDR_INSN     = 8'h00;
	localparam logic [7:0]  ADDR_PRIV     = 8'h04;
	localparam logic [7:0]  ADDR_PTE_LO   = 8'h08;
	localparam logic [7:0]  ADDR_PTE_HI   = 8'h0c;
	localparam logic [7:0]  ADDR_ATTR     = 8'h10;
	localparam logic [7:0]  ADDR_RESULT   = 8'h14;
	localparam logic [7:0]  ADDR_INV      = 8'h18;
	localparam logic [7:0]  ADDR_INV_VA   = 8'h1c;
	localparam logic [7:0]  ADDR_INV_TAG  = 8'h20;
	localparam logic [6:0]  OPC_SYSTEM    = 7'h73;
	localparam logic [6:0]  F7_SUP_INV    = 7'h0b;
	localparam logic [6:0]  F7_GV_INV     = 7'h13;
	localparam logic [6:0]  F7_GP_INV     = 7'h33;
	localparam logic [6:0]  F7_FENCE_GRP  = 7'h0c;
	localparam logic [4:0]  RS2_ST_INV    = 5'h00;
	localparam logic [4:0]  RS2_INV_IMP   = 5'h01;
	localparam int          PMT_HI        = 30;
	localparam int          PMT_LO        = 29;
	localparam logic [1:0]  PMT_KEEP      = 2'h0;
	localparam logic [1:0]  PMT_NC        = 2'h1;
	localparam logic [1:0]  PMT_IO        = 2'h2;
	localparam logic [1:0]  PMT_RSVD      = 2'h3;
	localparam logic [1:0]  ATTR_VACANT   = 2'h0;
	localparam logic [1:0]  ATTR_MAIN     = 2'h1;
	localparam logic [1:0]  ATTR_IO       = 2'h2;
	localparam logic [2:0]  MODE_U        = 3'h0;
	localparam logic [2:0]  MODE_S        = 3'h1;
	localparam logic [2:0]  MODE_M        = 3'h3;
	localparam logic [2:0]  MODE_VU       = 3'h4;
	localparam logic [2:0]  MODE_VS       = 3'h5;
	localparam logic [1:0]  EXC_NONE      = 2'h0;
	localparam logic [1:0]  EXC_ILLEGAL   = 2'h1;
	localparam logic [1:0]  EXC_VIRTUAL   = 2'h2;
	localparam logic [1:0]  EXC_PAGE      = 2'h3;
	localparam logic [1:0]  INV_SUP       = 2'h1;
	localparam logic [1:0]  INV_GV        = 2'h2;
	localparam logic [1:0]  INV_GP        = 2'h3;
	typedef enum logic [1:0] {
		IDLE   = 2'b00,
		WAIT   = 2'b01,
		ANSWER = 2'b11
	} bus_state_t;
endpackage

/* dv/translation_memtype_and_invalidation_asserts.sv */
// Port assertions for the translation block
`timescale 1ns/10ps
`default_nettype none
module translation_memtype_and_invalidation_asserts (
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic [7:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [31:0] srcVaddr,
	input wire logic [31:0] srcTag,
	input wire logic        flushValid,
	input wire logic [1:0]  flushKind,
	input wire logic [31:0] flushVaddr,
	input wire logic [15:0] flushTag,
	input wire logic        ioOrdered,
	input wire logic        fenceBoth
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_req; $rose(read || write); endsequence
	sequence s_wait2; waitrequest ##1 waitrequest ##1 !waitrequest; endsequence
	property p_wait2; s_req |-> s_wait2; endproperty
	a_wait2: assert property (p_wait2) else $error("Bus answer off two waits");
	property p_idle; !(read || write) |-> !waitrequest; endproperty
	a_idle: assert property (p_idle) else $error("Wait while idle");
	property p_pulse; flushValid |=> !flushValid; endproperty
	a_pulse: assert property (p_pulse) else $error("Flush longer than one cycle");
	property p_ack; flushValid |-> write && !waitrequest && address == xlate_pkg::ADDR_INV;
	endproperty
	a_ack: assert property (p_ack) else $error("Flush without execute");
	property p_kind; flushValid |-> flushKind != 2'h0; endproperty
	a_kind: assert property (p_kind) else $error("Flush kind empty");
	property p_oper; flushValid |-> flushVaddr == srcVaddr && flushTag == srcTag[15:0];
	endproperty
	a_oper: assert property (p_oper) else $error("Flush operands wrong");
	// Levels follow config only, so a change needs a recent write
	property p_io; !$stable(ioOrdered) |-> $past(write) || $past(write, 2); endproperty
	a_io: assert property (p_io) else $error("Ordering moved alone");
	property p_both; !$stable(fenceBoth) |-> $past(write) || $past(write, 2); endproperty
	a_both: assert property (p_both) else $error("Fence class moved alone");
	property p_rdhold; !$stable(readdata) |-> $past(read); endproperty
	a_rdhold: assert property (p_rdhold) else $error("Read data moved alone");
endmodule
`default_nettype wire

/* dv/hart_model.sv */
// Hart register file feeding invalidate operands
`timescale 1ns/10ps
`default_nettype none
module hart_model (
	input wire logic [31:0] insn,
	output logic [31:0]     srcVaddr,
	output logic [31:0]     srcTag
);
	logic [31:0] regs [32];
	integer      mseed = 3;
	initial begin
		for (int i = 0; i < 32; i++)
			regs[i] = (i == 0) ? 32'h0 : $random(mseed);
	end
	assign srcVaddr = regs[insn[19:15]];
	assign srcTag = regs[insn[24:20]];
endmodule
`default_nettype wire

/* dv/translation_memtype_and_invalidation_tb.sv */
// Bench for memory-type resolution and split invalidation
`timescale 1ns/10ps
`default_nettype none
module translation_memtype_and_invalidation_tb;
	logic        core_clk = 0, reset = 1, read = 0, write = 0;
	logic [7:0]  address = 8'h00;
	logic [31:0] writedata = 32'h0, insn = 32'h0, readdata, srcVaddr, srcTag, flushVaddr;
	logic        waitrequest, flushValid, flushAllAddr, flushAllTag, ioOrdered, fenceBoth;
	logic [1:0]  flushKind;
	logic [15:0] flushTag;
	logic [31:0] expQ[$], mskQ[$];
	logic [51:0] flQ[$];
	int          errorCnt = 0, numChecks = 0, seed = 3, nFlush = 0;
	always #5 core_clk = ~core_clk;
	translation_memtype_and_invalidation i_translation_memtype_and_invalidation (
		.core_clk, .reset, .address, .read, .write, .writedata, .readdata, .waitrequest,
		.srcVaddr, .srcTag, .flushValid, .flushKind, .flushVaddr, .flushTag,
		.flushAllAddr, .flushAllTag, .ioOrdered, .fenceBoth);
	hart_model i_hart_model (.insn, .srcVaddr, .srcTag);
	task automatic fail(input string m);
		$display("Error %0t: %s", $time, m);
		errorCnt++;
	endtask
	task automatic tally_and_finish;
		if (expQ.size() != 0 || flQ.size() != 0)
			fail("expected results never seen");
		$display("Checks %0d errors %0d", numChecks, errorCnt);
		if (errorCnt == 0 && numChecks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chkRd(input logic [31:0] g);
		numChecks++;
		if (expQ.size() == 0)
			fail("read not expected");
		else if ((g & mskQ[0]) !== (expQ[0] & mskQ[0]))
			fail("read data mismatch");
		void'(expQ.pop_front());
		void'(mskQ.pop_front());
	endtask
	task automatic chkLvl(input logic g, e);
		numChecks++;
		if (g !== e)
			fail("ordering level mismatch");
	endtask
	task automatic chkFl(input logic [51:0] g);
		numChecks++;
		if (flQ.size() == 0 || g !== flQ[0])
			fail("flush mismatch");
		void'(flQ.pop_front());
	endtask
	// Watcher: results come off the queues in issue order
	always @(posedge core_clk) begin
		if (reset === 1'b0 && read === 1'b1 && waitrequest === 1'b0)
			chkRd(readdata);
		if (reset === 1'b0 && flushValid !== 1'b0)
			chkFl({flushKind, flushVaddr, flushTag, flushAllAddr, flushAllTag});
	end
	task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 40);
		if (waitrequest !== 1'b0) begin
			fail("bus timeout");
			tally_and_finish;
		end
		read <= 1'b0;
		write <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m);
		expQ.push_back(e);
		mskQ.push_back(m);
		acc(1'b0, a, 32'h0);
	endtask
	function automatic logic [1:0] ovr(input logic [1:0] a, t, input logic on);
		return (on && t != 2'h0 && a != xlate_pkg::ATTR_VACANT) ? t : a;
	endfunction
	function automatic logic [1:0] excOf(input int k, input logic [2:0] m, input logic tv, vt);
		if (k == 5 || m == xlate_pkg::MODE_U)
			return xlate_pkg::EXC_ILLEGAL;
		if (m == xlate_pkg::MODE_VU || (m == xlate_pkg::MODE_VS && (k == 1 || k == 2 || (k == 0 && vt))))
			return xlate_pkg::EXC_VIRTUAL;
		if (m == xlate_pkg::MODE_S && tv && (k == 0 || k == 2))
			return xlate_pkg::EXC_ILLEGAL;
		return xlate_pkg::EXC_NONE;
	endfunction
	initial begin
		logic [31:0] r;
		logic [1:0]  ph, mid, fin, ex;
		logic        flt;
		logic [4:0]  s1, s2;
		logic [6:0]  f7[6] = '{7'h0b, 7'h13, 7'h33, 7'h0c, 7'h0c, 7'h0b};
		logic [2:0]  md[5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5};
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		rd(xlate_pkg::ADDR_RESULT, 32'h0, 32'hffffffff);
		repeat (60) begin
			r = $random(seed);
			ph = (r[1:0] == 2'h3) ? 2'h2 : r[1:0];
			acc(1'b1, xlate_pkg::ADDR_PRIV, {22'h0, r[8], r[9], 8'h01});
			acc(1'b1, xlate_pkg::ADDR_PTE_LO, {1'b0, r[3:2], 28'h0, r[6]});
			acc(1'b1, xlate_pkg::ADDR_PTE_HI, {1'b0, r[5:4], 28'h0, r[7]});
			acc(1'b1, xlate_pkg::ADDR_ATTR, {27'h0, r[10] & r[11], 2'h0, ph});
			mid = ovr(ph, r[5:4], r[9] && r[7]);
			fin = ovr(mid, r[3:2], r[8] && r[6]);
			flt = (r[9] && (r[7] ? r[5:4] == 2'h3 : r[5:4] != 2'h0))
				|| (r[8] && (r[6] ? r[3:2] == 2'h3 : r[3:2] != 2'h0));
			// Misaligned I/O may fault, so its code is left open
			rd(xlate_pkg::ADDR_RESULT, {24'h0, fin != ph, fin == 2'h2, flt ? 2'h3 : 2'h0, 2'h0, fin},
				flt ? 32'h30 : (r[10] & r[11] & fin == 2'h2) ? 32'hc3 : 32'hf3);
			if (!flt) begin
				chkLvl(ioOrdered, fin == 2'h2);
				chkLvl(fenceBoth, fin != ph);
			end
		end
		for (int k = 0; k < 6; k++) for (int m = 0; m < 5; m++) for (int t = 0; t < 4; t++) begin
			r = $random(seed);
			s1 = (r[2] || k > 2) ? 5'h0 : r[7:3];
			s2 = (k == 4) ? 5'h1 : (r[8] || k == 3) ? 5'h0 : r[13:9];
			insn <= {f7[k], s2, s1, 3'h0, (k == 5) ? 5'h1 : 5'h0, xlate_pkg::OPC_SYSTEM};
			acc(1'b1, xlate_pkg::ADDR_PRIV, {26'h0, t[1], t[0], 1'b0, md[m]});
			acc(1'b1, xlate_pkg::ADDR_INSN, insn);
			ex = excOf(k, md[m], t[0], t[1]);
			if (ex == xlate_pkg::EXC_NONE && k < 3) begin
				flQ.push_back({2'(k + 1), i_hart_model.regs[s1], i_hart_model.regs[s2][15:0],
					s1 == 5'h0, s2 == 5'h0});
				nFlush++;
			end
			acc(1'b1, xlate_pkg::ADDR_INV, r);
			rd(xlate_pkg::ADDR_INV, {29'h0, ex == 2'h0, ex}, 32'h7);
		end
		rd(xlate_pkg::ADDR_INV_VA, 32'(nFlush), 32'hffff);
		acc(1'b1, 8'h40, $random(seed));
		rd(8'h40, 32'h0, 32'hffffffff);
		tally_and_finish;
	end
endmodule
bind translation_memtype_and_invalidation translation_memtype_and_invalidation_asserts i_asserts (
	.core_clk, .reset, .address, .read, .write, .readdata, .waitrequest, .srcVaddr, .srcTag,
	.flushValid, .flushKind, .flushVaddr, .flushTag, .ioOrdered, .fenceBoth);
`default_nettype wire
